// >>> hw/sccg_defines.svh
/*
 * Constants for the sample clock generator control block: register
 * addresses, reset values, write masks, field codes and rates.
 * Assumes control register addresses are five bits wide and data is
 * sixteen bits, as carried in the control slots of the serial frame.
 */
// Summary of operation
// - Rate field gives generator 1 sample rate in 1 Hz steps, 4 to 54 kHz.
// - Rate field resets to 48 kHz, held and unwritable during reset or power-down.
// - Phase bit 8 picks direction: zero advances, one retards the sample clock.
// - Phase magnitude counts 0.12 degree steps, applied and decremented at 3.072 MHz.
// - Phase read returns pending shift sampled at slot 0 or slot-start input.
// - A new phase value may be written whenever the phase register is not held, and replaces unapplied shift.
// - Any control write sends the register's prior contents in next frame slot 1; only the last write of a frame is echoed.
// - Phase register cleared and unwritable in reset, power-down or generator 1 disabled.
// - Reference select zero: master clock reference, shiftable phase, video bit ignored.
// - Reference select one: lock to sync input, no phase shift, 8/7 ignored.
// - Video bit zero locks conversion clock with bit clock; one gives no bit clock.
// - Loop-gain bit zero selects finite gain, one selects infinite gain.
// - Plus-200 bit raises bit clock by 200 Hz, ignored in video lock.
// - Eight-sevenths bit scales conversion rate by 8/7 unless sync referenced.
// - Conversion pin runs 128 times conversion rate when multiplier bit set.
// - Low modifier codes 0 to 11 give 2400 to 28800 Hz; 12 to 14 reserved.
// - Both modifier nibbles all ones give bit clock of 128 times conversion rate.
// - Video lock: top bit NTSC or PAL, next three base, low four divisor.
// - Mode register resets to 00FF, held and unwritable in reset or power-down.
`ifndef SCCG_DEFINES_SVH
`define SCCG_DEFINES_SVH

`define SCCG_ADDR_GEN1_RATE   5'h11
`define SCCG_ADDR_GEN1_PHASE  5'h12
`define SCCG_ADDR_GEN2_MODE   5'h13

`define SCCG_RATE_RESET       16'hBB80
`define SCCG_RATE_MIN         16'h0FA0
`define SCCG_RATE_MAX         16'hD2F0
`define SCCG_PHASE_RESET      16'h0000
`define SCCG_MODE_RESET       16'h00FF
`define SCCG_PHASE_WMASK      16'h01FF
`define SCCG_MODE_WMASK       16'hFCFF

// Clock and step rates in kHz; step tick is their ratio
`define SCCG_CLK_KHZ          17'h0C350
`define SCCG_STEP_KHZ         17'h00C00

`define SCCG_BITCLK_STEP_HZ   16'h0960
`define SCCG_PLUS200_HZ       16'h00C8
`define SCCG_BITCLK_MAX_CODE  4'hB
`define SCCG_MOD_ALL_ONES     8'hFF
`define SCCG_MAG_ZERO         8'h00
`define SCCG_MAG_ONE          8'h01

`endif

// >>> hw/sccg_pkg.sv
/*
 * Types for the sample clock generator control block.
 * Assumes sccg_defines.svh supplies the numeric constants.
 */
package sccg_pkg;

    // Generator 2 mode register, bit 15 down to bit 0
    typedef struct packed {
        logic       ref_sel;
        logic       video;
        logic       loop_gain;
        logic       plus200;
        logic       eight_sev;
        logic       convpin_x128;
        logic [1:0] rsvd;
        logic [7:0] modifiers;
    } sccg_mode_t;

    typedef struct packed {
        logic [6:0] rsvd;
        logic       dir;
        logic [7:0] mag;
    } sccg_phase_t;

    // Control register access decoded from the frame slots
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } sccg_ctrl_req_t;

    // Decoded generator 2 settings for the clock synthesiser
    typedef struct packed {
        logic        xtal_ref;
        logic        phase_shiftable;
        logic        video_lock;
        logic        pal_ref;
        logic        loop_gain_inf;
        logic        eight_sev_eff;
        logic        convpin_x128;
        logic        bitclk_on;
        logic        bitclk_x128;
        logic        bitclk_reserved;
        logic [15:0] bitclk_hz;
        logic [2:0]  video_base;
        logic [4:0]  video_div;
    } sccg_gen2_cfg_t;

endpackage

// >>> hw/sccg_step_tick.sv
/*
 * Fractional tick generator: one-cycle pulses at the phase step rate,
 * averaged exactly over time from the system clock.
 * Assumes a single clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sccg_defines.svh"

module sccg_step_tick (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    // Step pulse
    output var  logic tick_r
);
    logic [16:0] acc_r;
    logic [16:0] acc_sum;

    // Phase accumulator; jitter of one clock is the price of a 50 MHz clock
    assign acc_sum = acc_r + `SCCG_STEP_KHZ;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            acc_r  <= 17'h00000;
            tick_r <= 1'b0;
        end else if (acc_sum >= `SCCG_CLK_KHZ) begin
            acc_r  <= acc_sum - `SCCG_CLK_KHZ;
            tick_r <= 1'b1;
        end else begin
            acc_r  <= acc_sum;
            tick_r <= 1'b0;
        end
    end

    tick_spacing_a: assert property (@(posedge clock) disable iff (!reset_n)
        tick_r |=> !tick_r ##1 !tick_r ##1 !tick_r ##1 !tick_r ##1 !tick_r ##1 !tick_r ##1 !tick_r ##1 !tick_r ##1 !tick_r ##1 !tick_r ##1 !tick_r ##1 !tick_r ##1 !tick_r ##1 !tick_r ##1 !tick_r)
        else $error("step ticks closer than the step period");

endmodule
`default_nettype wire

// >>> hw/sccg_ctrl.sv
/*
 * Sample clock generator control: generator 1 rate and phase shift
 * registers with the phase stepper, and generator 2 mode register with
 * its decoded settings. Registers are reached through the control
 * register slots of the serial frame.
 * Assumes the frame logic delivers decoded control accesses and a
 * slot 0 start pulse on this clock, and that the generator 1 enable
 * bit comes from the enable register on this clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sccg_defines.svh"

module sccg_ctrl
    import sccg_pkg::*;
(
    // Clock and reset
    input  wire logic           clock,
    input  wire logic           reset_n,
    // Pins
    input  wire logic           power_down_pin_n,
    input  wire logic           slot_start_input,
    // Frame logic
    input  wire sccg_ctrl_req_t ctrl_req,
    input  wire logic           frame_master,
    input  wire logic           slot0_start,
    output var  logic [15:0]    rd_data_r,
    output var  logic           rd_valid_r,
    output var  logic [15:0]    slot1_data_r,
    output var  logic           slot1_valid_r,
    // Enable register
    input  wire logic           gen1_enable_bit,
    // Generator 1
    output var  logic [15:0]    gen1_rate_field_r,
    output var  logic           gen1_rate_usable_r,
    output var  logic           step_advance_r,
    output var  logic           step_retard_r,
    // Generator 2
    output var  sccg_mode_t     gen2_mode_r,
    output var  sccg_gen2_cfg_t gen2_cfg_r
);
    logic        pwr_meta_r;
    logic        pwr_ok_r;
    logic        ssi_meta_r;
    logic        ssi_sync_r;
    logic        ssi_prev_r;
    logic        frame_evt;
    logic        step_tick;
    sccg_phase_t phase_r;
    sccg_phase_t phase_snap_r;
    logic [15:0] prior_r;
    logic        prior_pend_r;
    logic [15:0] cur_val;
    logic        wr_rate;
    logic        wr_phase;
    logic        wr_mode;
    logic        phase_hold;
    logic        video_nxt;
    logic        bit_on_nxt;
    logic [15:0] bit_hz_nxt;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    // Pin synchronisers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pwr_meta_r <= 1'b0;
            pwr_ok_r   <= 1'b0;
        end else begin
            pwr_meta_r <= power_down_pin_n;
            pwr_ok_r   <= pwr_meta_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ssi_meta_r <= 1'b0;
            ssi_sync_r <= 1'b0;
            ssi_prev_r <= 1'b0;
        end else begin
            ssi_meta_r <= slot_start_input;
            ssi_sync_r <= ssi_meta_r;
            ssi_prev_r <= ssi_sync_r;
        end
    end

    // Sample point of the pending shift, per frame role
    assign frame_evt = frame_master ? slot0_start : (ssi_sync_r & ~ssi_prev_r);

    sccg_step_tick u_step_tick (
        .clock   (clock),
        .reset_n (reset_n),
        .tick_r  (step_tick)
    );

    // Write decode; writes are dropped while held at default
    assign wr_rate    = ctrl_req.wr && (ctrl_req.addr == `SCCG_ADDR_GEN1_RATE) && pwr_ok_r;
    assign phase_hold = !pwr_ok_r || !gen1_enable_bit;
    assign wr_phase   = ctrl_req.wr && (ctrl_req.addr == `SCCG_ADDR_GEN1_PHASE) && !phase_hold;
    assign wr_mode    = ctrl_req.wr && (ctrl_req.addr == `SCCG_ADDR_GEN2_MODE) && pwr_ok_r;

    // Generator 1 sample rate
    always_ff @(posedge clock) begin
        if (!reset_n || !pwr_ok_r) begin
            gen1_rate_field_r <= `SCCG_RATE_RESET;
        end else if (wr_rate) begin
            gen1_rate_field_r <= ctrl_req.wdata;
        end
    end

    // Values outside the usable range are stored but flagged
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            gen1_rate_usable_r <= 1'b1;
        end else begin
            gen1_rate_usable_r <= (gen1_rate_field_r >= `SCCG_RATE_MIN) &&
                                  (gen1_rate_field_r <= `SCCG_RATE_MAX);
        end
    end

    // Phase register: a write replaces any unapplied remainder
    always_ff @(posedge clock) begin
        if (!reset_n || phase_hold) begin
            phase_r <= `SCCG_PHASE_RESET;
        end else if (wr_phase) begin
            phase_r <= ctrl_req.wdata & `SCCG_PHASE_WMASK;
        end else if (step_tick && (phase_r.mag != `SCCG_MAG_ZERO)) begin
            phase_r.mag <= phase_r.mag - `SCCG_MAG_ONE;
        end
    end

    // One step pulse per applied 0.12 degree unit
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            step_advance_r <= 1'b0;
            step_retard_r  <= 1'b0;
        end else begin
            step_advance_r <= !phase_hold && !wr_phase && step_tick &&
                              (phase_r.mag != `SCCG_MAG_ZERO) && !phase_r.dir;
            step_retard_r  <= !phase_hold && !wr_phase && step_tick &&
                              (phase_r.mag != `SCCG_MAG_ZERO) && phase_r.dir;
        end
    end

    // Pending shift as seen at the frame sample point
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            phase_snap_r <= `SCCG_PHASE_RESET;
        end else if (frame_evt) begin
            phase_snap_r <= phase_r;
        end
    end

    // Generator 2 mode register
    always_ff @(posedge clock) begin
        if (!reset_n || !pwr_ok_r) begin
            gen2_mode_r <= `SCCG_MODE_RESET;
        end else if (wr_mode) begin
            gen2_mode_r <= ctrl_req.wdata & `SCCG_MODE_WMASK;
        end
    end

    // Contents of the addressed register before the write lands
    always_comb begin
        unique case (ctrl_req.addr)
            `SCCG_ADDR_GEN1_RATE:  cur_val = gen1_rate_field_r;
            `SCCG_ADDR_GEN1_PHASE: cur_val = phase_r;
            `SCCG_ADDR_GEN2_MODE:  cur_val = gen2_mode_r;
            default:               cur_val = 16'h0000;
        endcase
    end

    // Echo of prior contents; a write in the frame cycle stays pending
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            prior_r      <= 16'h0000;
            prior_pend_r <= 1'b0;
        end else if (ctrl_req.wr) begin
            prior_r      <= cur_val;
            prior_pend_r <= 1'b1;
        end else if (frame_evt) begin
            prior_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            slot1_data_r  <= 16'h0000;
            slot1_valid_r <= 1'b0;
        end else if (frame_evt) begin
            slot1_data_r  <= prior_r;
            slot1_valid_r <= prior_pend_r;
        end
    end

    // Register read; the phase register returns the sampled pending shift
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rd_data_r  <= 16'h0000;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= ctrl_req.rd;
            if (ctrl_req.rd) begin
                unique case (ctrl_req.addr)
                    `SCCG_ADDR_GEN1_RATE:  rd_data_r <= gen1_rate_field_r;
                    `SCCG_ADDR_GEN1_PHASE: rd_data_r <= phase_snap_r;
                    `SCCG_ADDR_GEN2_MODE:  rd_data_r <= gen2_mode_r;
                    default:               rd_data_r <= 16'h0000;
                endcase
            end
        end
    end

    // Generator 2 decode
    assign video_nxt  = gen2_mode_r.ref_sel && gen2_mode_r.video;
    assign bit_on_nxt = !video_nxt;

    // Bit clock table; reserved codes report zero Hz
    always_comb begin
        bit_hz_nxt = 16'h0000;
        if (gen2_mode_r.modifiers[3:0] <= `SCCG_BITCLK_MAX_CODE) begin
            bit_hz_nxt = `SCCG_BITCLK_STEP_HZ * ({12'h000, gen2_mode_r.modifiers[3:0]} + 16'h0001);
            if (gen2_mode_r.plus200) begin
                bit_hz_nxt = bit_hz_nxt + `SCCG_PLUS200_HZ;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            gen2_cfg_r <= '0;
        end else begin
            gen2_cfg_r.xtal_ref        <= !gen2_mode_r.ref_sel;
            gen2_cfg_r.phase_shiftable <= !gen2_mode_r.ref_sel;
            gen2_cfg_r.video_lock      <= video_nxt;
            gen2_cfg_r.pal_ref         <= video_nxt && gen2_mode_r.modifiers[7];
            gen2_cfg_r.loop_gain_inf   <= gen2_mode_r.loop_gain;
            gen2_cfg_r.eight_sev_eff   <= !gen2_mode_r.ref_sel && gen2_mode_r.eight_sev;
            gen2_cfg_r.convpin_x128    <= gen2_mode_r.convpin_x128;
            gen2_cfg_r.bitclk_on       <= bit_on_nxt;
            gen2_cfg_r.bitclk_x128     <= bit_on_nxt &&
                                          (gen2_mode_r.modifiers == `SCCG_MOD_ALL_ONES);
            gen2_cfg_r.bitclk_reserved <= bit_on_nxt &&
                                          (gen2_mode_r.modifiers != `SCCG_MOD_ALL_ONES) &&
                                          (gen2_mode_r.modifiers[3:0] > `SCCG_BITCLK_MAX_CODE);
            gen2_cfg_r.bitclk_hz       <= bit_on_nxt ? bit_hz_nxt : 16'h0000;
            gen2_cfg_r.video_base      <= video_nxt ? gen2_mode_r.modifiers[6:4] : 3'h0;
            gen2_cfg_r.video_div       <= video_nxt ?
                                          ({1'b0, gen2_mode_r.modifiers[3:0]} + 5'h01) : 5'h00;
        end
    end

    // Checks
    rate_held_a: assert property (@(posedge clock) disable iff (!reset_n)
        !pwr_ok_r |=> gen1_rate_field_r == `SCCG_RATE_RESET)
        else $error("rate field not held at default");

    mode_held_a: assert property (@(posedge clock) disable iff (!reset_n)
        (!pwr_ok_r && ctrl_req.wr) |=> gen2_mode_r == `SCCG_MODE_RESET)
        else $error("mode register written while held");

    phase_cleared_a: assert property (@(posedge clock) disable iff (!reset_n)
        !gen1_enable_bit |=> phase_r == `SCCG_PHASE_RESET)
        else $error("phase register not cleared while disabled");

    phase_replace_a: assert property (@(posedge clock) disable iff (!reset_n)
        wr_phase |=> phase_r == ($past(ctrl_req.wdata) & `SCCG_PHASE_WMASK))
        else $error("phase write did not replace pending shift");

    step_count_a: assert property (@(posedge clock) disable iff (!reset_n)
        (step_tick && !wr_phase && !phase_hold && phase_r.mag != `SCCG_MAG_ZERO)
        |=> (phase_r.mag == $past(phase_r.mag) - `SCCG_MAG_ONE) &&
            (step_advance_r || step_retard_r))
        else $error("step not applied and counted");

    step_sense_a: assert property (@(posedge clock) disable iff (!reset_n)
        (step_advance_r |-> !$past(phase_r.dir)) and (step_retard_r |-> $past(phase_r.dir)))
        else $error("step direction wrong");

    zero_stop_a: assert property (@(posedge clock) disable iff (!reset_n)
        (phase_r.mag == `SCCG_MAG_ZERO && !wr_phase) |=> phase_r.mag == `SCCG_MAG_ZERO &&
            !step_advance_r && !step_retard_r)
        else $error("stepping past zero");

    snap_sample_a: assert property (@(posedge clock) disable iff (!reset_n)
        frame_evt |=> phase_snap_r == $past(phase_r))
        else $error("pending shift not sampled at frame point");

    prior_echo_a: assert property (@(posedge clock) disable iff (!reset_n)
        (ctrl_req.wr && !frame_evt) ##1 (!ctrl_req.wr && frame_evt)
        |=> slot1_valid_r && slot1_data_r == $past(cur_val, 2))
        else $error("prior contents not echoed in slot 1");

    bitclk_x128_a: assert property (@(posedge clock) disable iff (!reset_n)
        (gen2_mode_r.modifiers == `SCCG_MOD_ALL_ONES && !video_nxt) |=> gen2_cfg_r.bitclk_x128)
        else $error("all-ones modifiers did not select x128 bit clock");

    video_nobit_a: assert property (@(posedge clock) disable iff (!reset_n)
        video_nxt |=> !gen2_cfg_r.bitclk_on && gen2_cfg_r.bitclk_hz == 16'h0000)
        else $error("bit clock produced in video lock");

    sync_ref_a: assert property (@(posedge clock) disable iff (!reset_n)
        gen2_mode_r.ref_sel |=> !gen2_cfg_r.eight_sev_eff && !gen2_cfg_r.phase_shiftable)
        else $error("sync reference still honours 8/7 or phase shift");

    rate_write_a: assert property (
        wr_rate |=> gen1_rate_field_r == $past(ctrl_req.wdata))
        else $error("rate write lost");

    rate_usable_a: assert property (
        (gen1_rate_field_r < `SCCG_RATE_MIN) |=> !gen1_rate_usable_r)
        else $error("low rate usable");

    phase_blocked_a: assert property (
        ctrl_req.wr && phase_hold |=> phase_r == `SCCG_PHASE_RESET)
        else $error("held phase written");

    phase_read_a: assert property (
        ctrl_req.rd && ctrl_req.addr == `SCCG_ADDR_GEN1_PHASE |=> rd_data_r == $past(phase_snap_r))
        else $error("phase read wrong");

    step_tick_a: assert property (
        step_advance_r || step_retard_r |-> $past(step_tick))
        else $error("step off tick");

    xtal_ref_a: assert property (
        !gen2_mode_r.ref_sel |=> gen2_cfg_r.xtal_ref && !gen2_cfg_r.video_lock)
        else $error("video bit not ignored");

    eight_sev_a: assert property (
        !gen2_mode_r.ref_sel && gen2_mode_r.eight_sev |=> gen2_cfg_r.eight_sev_eff)
        else $error("8/7 bit ignored");

    loop_gain_a: assert property (
        gen2_cfg_r.loop_gain_inf == $past(gen2_mode_r.loop_gain))
        else $error("loop gain wrong");

    line_ref_a: assert property (
        video_nxt |=> gen2_cfg_r.pal_ref == $past(gen2_mode_r.modifiers[7]))
        else $error("line reference wrong");

endmodule
`default_nettype wire

// >>> sim/sccg_frame_host.sv
/*
 * Frame host model: periodic frame events seen by the control block,
 * both the slot 0 start pulse and the slot-start pin.
 * Assumes the bench clock and reset; frames run only out of reset.
 */
`timescale 1ns/1ps
`default_nettype none

module sccg_frame_host #(
    parameter int FRAME_LEN = 64
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    // Frame events
    output var  logic slot0_start,
    output var  logic slot_start_input
);
    int cnt;

    always_ff @(posedge clock) begin
        if (!reset_n) cnt <= 0;
        else cnt <= (cnt == FRAME_LEN - 1) ? 0 : cnt + 1;
    end

    // Pin held two cycles so its synchroniser sees it; low between frames
    assign slot0_start      = reset_n && cnt == 1;
    assign slot_start_input = reset_n && cnt > 0 && cnt < 3;
endmodule

`default_nettype wire

// >>> sim/sccg_ctrl_tb.sv
/*
 * Self-checking bench for the sample clock generator control block.
 * Assumes the frame host model supplies frame events.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sccg_defines.svh"

module sccg_ctrl_tb;
    import sccg_pkg::*;

    logic           clock = 1'b0;
    logic           reset_n = 1'b0;
    logic           power_down_pin_n = 1'b1;
    logic           frame_master = 1'b1;
    logic           gen1_enable_bit = 1'b1;
    sccg_ctrl_req_t ctrl_req = '0;
    logic           slot0_start, slot_start_input, rd_valid_r, slot1_valid_r;
    logic           gen1_rate_usable_r, step_advance_r, step_retard_r;
    logic [15:0]    rd_data_r, slot1_data_r, gen1_rate_field_r, v;
    sccg_mode_t     gen2_mode_r;
    sccg_gen2_cfg_t gen2_cfg_r;
    logic [31:0]    seed, e;
    logic [31:0]    exp_q[$];
    logic [15:0]    rates[4] = '{16'h0FA0, 16'hD2F0, 16'h0F9F, 16'hD2F1};
    int             mismatches = 0, checks = 0, adv_cnt = 0, ret_cnt = 0;

    always #10 clock = ~clock;

    sccg_frame_host sccg_frame_host_i (.clock(clock), .reset_n(reset_n),
        .slot0_start(slot0_start), .slot_start_input(slot_start_input));

    sccg_ctrl sccg_ctrl_i (.clock(clock), .reset_n(reset_n),
        .power_down_pin_n(power_down_pin_n), .slot_start_input(slot_start_input),
        .ctrl_req(ctrl_req), .frame_master(frame_master), .slot0_start(slot0_start),
        .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .slot1_data_r(slot1_data_r),
        .slot1_valid_r(slot1_valid_r), .gen1_enable_bit(gen1_enable_bit),
        .gen1_rate_field_r(gen1_rate_field_r), .gen1_rate_usable_r(gen1_rate_usable_r),
        .step_advance_r(step_advance_r), .step_retard_r(step_retard_r),
        .gen2_mode_r(gen2_mode_r), .gen2_cfg_r(gen2_cfg_r));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    function automatic sccg_gen2_cfg_t exp_cfg(input sccg_mode_t m);
        sccg_gen2_cfg_t c;
        c = '0;
        c.xtal_ref        = !m.ref_sel;
        c.phase_shiftable = !m.ref_sel;
        c.video_lock      = m.ref_sel && m.video;
        c.loop_gain_inf   = m.loop_gain;
        c.eight_sev_eff   = m.eight_sev && !m.ref_sel;
        c.convpin_x128    = m.convpin_x128;
        c.bitclk_on       = !c.video_lock;
        if (c.video_lock) begin
            c.pal_ref    = m.modifiers[7];
            c.video_base = m.modifiers[6:4];
            c.video_div  = {1'b0, m.modifiers[3:0]} + 5'h01;
        end else if (m.modifiers == `SCCG_MOD_ALL_ONES) c.bitclk_x128 = 1'b1;
        else if (m.modifiers[3:0] > `SCCG_BITCLK_MAX_CODE) c.bitclk_reserved = 1'b1;
        else c.bitclk_hz = ({12'h000, m.modifiers[3:0]} + 16'h0001) * `SCCG_BITCLK_STEP_HZ
                + (m.plus200 ? `SCCG_PLUS200_HZ : 16'h0000);
        return c;
    endfunction

    // Fields with no defined meaning in the current mode are not compared
    function automatic logic [39:0] mask_cfg(input sccg_gen2_cfg_t c);
        if (c.video_lock === 1'b1) begin
            c.bitclk_hz       = '0;
            c.bitclk_reserved = 1'b0;
            c.bitclk_x128     = 1'b0;
        end else begin
            c.pal_ref    = 1'b0;
            c.video_base = '0;
            c.video_div  = '0;
        end
        return {6'h00, c};
    endfunction

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Counts are cleared once the write has been taken
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        ctrl_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clock);
        ctrl_req = '0;
        adv_cnt = 0;
        ret_cnt = 0;
        @(negedge clock);
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] d, input logic [15:0] m);
        exp_q.push_back({m, d});
        ctrl_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge clock);
        ctrl_req = '0;
        @(negedge clock);
    endtask

    task automatic wait_frame(input int extra);
        @(posedge slot0_start);
        repeat (3 + extra) @(negedge clock);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clock) begin
        adv_cnt += step_advance_r;
        ret_cnt += step_retard_r;
    end

    always @(negedge clock) begin
        if (rd_valid_r === 1'b1) begin
            if (exp_q.size() == 0) check(40'h1, 40'h0);
            else begin
                e = exp_q.pop_front();
                check({24'h0, rd_data_r & e[31:16]}, {24'h0, e[15:0]});
            end
        end
    end

    initial begin
        #400000;
        mismatches++;
        give_verdict();
    end

    initial begin
        seed = 32'hEFB90BF2;
        repeat (6) @(negedge clock);
        reset_n = 1'b1;
        repeat (4) @(negedge clock);
        check({24'h0, gen1_rate_field_r}, {24'h0, `SCCG_RATE_RESET});
        check({24'h0, gen2_mode_r}, {24'h0, `SCCG_MODE_RESET});
        rd(`SCCG_ADDR_GEN1_PHASE, `SCCG_PHASE_RESET, 16'hFFFF);
        rd(5'h05, 16'h0000, 16'hFFFF);
        $display("test defaults done");
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            v = (i < 4) ? rates[i] : `SCCG_RATE_MIN + 16'(seed % 32'h0000C351);
            wr(`SCCG_ADDR_GEN1_RATE, v);
            check({24'h0, gen1_rate_field_r}, {24'h0, v});
            check({39'h0, gen1_rate_usable_r},
                  {39'h0, v >= `SCCG_RATE_MIN && v <= `SCCG_RATE_MAX});
            rd(`SCCG_ADDR_GEN1_RATE, v, 16'hFFFF);
        end
        $display("test rate done");
        wr(`SCCG_ADDR_GEN1_PHASE, 16'h0005);
        repeat (120) @(negedge clock);
        check({adv_cnt[19:0], ret_cnt[19:0]}, {20'd5, 20'd0});
        wr(`SCCG_ADDR_GEN1_PHASE, 16'h01FF);
        repeat (50) @(negedge clock);
        wr(`SCCG_ADDR_GEN1_PHASE, 16'h0002);
        repeat (100) @(negedge clock);
        check({adv_cnt[19:0], ret_cnt[19:0]}, {20'd2, 20'd0});
        wr(`SCCG_ADDR_GEN1_PHASE, 16'h0103);
        repeat (100) @(negedge clock);
        check({adv_cnt[19:0], ret_cnt[19:0]}, {20'd0, 20'd3});
        $display("test stepping done");
        wait_frame(0);
        wr(`SCCG_ADDR_GEN2_MODE, 16'h0F0F);
        wr(`SCCG_ADDR_GEN2_MODE, 16'h1234);
        check({24'h0, gen2_mode_r}, 40'h0000001034);
        wait_frame(0);
        check({23'h0, slot1_valid_r, slot1_data_r}, 40'h0000010C0F);
        wr(`SCCG_ADDR_GEN1_PHASE, 16'h0150);
        rd(`SCCG_ADDR_GEN1_PHASE, 16'h0100, 16'hFFFF);
        wait_frame(0);
        rd(`SCCG_ADDR_GEN1_PHASE, 16'h0100, 16'hFF00);
        frame_master = 1'b0;
        wr(`SCCG_ADDR_GEN1_PHASE, 16'h0050);
        wait_frame(4);
        rd(`SCCG_ADDR_GEN1_PHASE, 16'h0000, 16'hFF00);
        frame_master = 1'b1;
        repeat (1500) @(negedge clock);
        $display("test readback done");
        wr(`SCCG_ADDR_GEN1_PHASE, 16'h0180);
        gen1_enable_bit = 1'b0;
        repeat (10) @(negedge clock);
        wr(`SCCG_ADDR_GEN1_PHASE, 16'h0010);
        repeat (60) @(negedge clock);
        check({adv_cnt[19:0], ret_cnt[19:0]}, 40'h0);
        wait_frame(0);
        rd(`SCCG_ADDR_GEN1_PHASE, 16'h0000, 16'hFFFF);
        gen1_enable_bit = 1'b1;
        wr(`SCCG_ADDR_GEN1_RATE, 16'h1F40);
        wr(`SCCG_ADDR_GEN2_MODE, 16'h0003);
        power_down_pin_n = 1'b0;
        repeat (5) @(negedge clock);
        wr(`SCCG_ADDR_GEN1_RATE, 16'h2000);
        wr(`SCCG_ADDR_GEN2_MODE, 16'h0001);
        check({8'h0, gen1_rate_field_r, gen2_mode_r},
              {8'h0, `SCCG_RATE_RESET, `SCCG_MODE_RESET});
        power_down_pin_n = 1'b1;
        repeat (4) @(negedge clock);
        wr(`SCCG_ADDR_GEN1_RATE, 16'h1F40);
        check({24'h0, gen1_rate_field_r}, 40'h0000001F40);
        $display("test power down done");
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            v = (i < 16) ? {3'h0, i[0], 4'h4, 4'h3, i[3:0]} :
                (i == 16) ? 16'h00FF : (i == 17) ? 16'hC0A3 : seed[15:0] & `SCCG_MODE_WMASK;
            wr(`SCCG_ADDR_GEN2_MODE, v);
            @(negedge clock);
            check({24'h0, gen2_mode_r}, {24'h0, v});
            check(mask_cfg(gen2_cfg_r), mask_cfg(exp_cfg(v)));
        end
        $display("test mode decode done");
        repeat (4) @(negedge clock);
        give_verdict();
    end
endmodule

`default_nettype wire
